// ===== logic/hef_event_frames_defs.vh
`ifndef HEF_EVENT_FRAMES_DEFS_VH
`define HEF_EVENT_FRAMES_DEFS_VH

// ==========================================================
// frame header bytes
`define HEF_FRAME_TYPE      8'h80
`define HEF_GRP_CHAN        8'h08
`define HEF_GRP_PIN         8'h09
`define HEF_GRP_PROF        8'h0A
`define HEF_ID_DATA         8'h03
`define HEF_ID_CLOSED       8'h04
`define HEF_ID_CRLOW        8'h05
`define HEF_ID_CRGRANT      8'h06
`define HEF_ID_REJECT       8'h07
`define HEF_ID_PIN          8'h01
`define HEF_ID_PROF         8'h01
`define HEF_LEN_DATA        8'h04
`define HEF_LEN_CHAN        8'h05
`define HEF_LEN_PIN         8'h09
`define HEF_LEN_PROF        8'h01

// ==========================================================
// frame header sizes in bytes
`define HEF_HDR_DATA        4'd8
`define HEF_HDR_CHAN        4'd9
`define HEF_HDR_PIN         4'd13
`define HEF_HDR_PROF        4'd5

// ==========================================================
// profile status bits
`define HEF_ST_UNACK        0
`define HEF_ST_ACK          1
`define HEF_ST_DATA_MODE    5

// ==========================================================
// register byte offsets
`define HEF_OFS_PIN_IRQ_EN  8'h00
`define HEF_OFS_PIN_FUNC    8'h04
`define HEF_OFS_IRQ_STATUS  8'h08
`define HEF_OFS_IRQ_MASK    8'h0C
`define HEF_OFS_STATE       8'h10

// ==========================================================
// interrupt status bits
`define HEF_IRQ_SENT        0
`define HEF_IRQ_DROP        1
`define HEF_IRQ_MODE        2

// ==========================================================
// reset values
`define HEF_RST_PIN_IRQ_EN  8'h00
`define HEF_RST_PIN_FUNC    8'h00
`define HEF_RST_IRQ_MASK    3'h0

// ==========================================================
// timing
`define HEF_CLK_HZ          20000000
`define HEF_SUBSEC_HZ       32768
`define HEF_SUBSEC_CYC      16'h0262

`endif

// ===== logic/hef_event_frames.v
`include "hef_event_frames_defs.vh"

module hef_event_frames #(
    parameter [7:0]  PORT_NUM   = 8'h00,
    parameter [15:0] SUBSEC_CYC = `HEF_SUBSEC_CYC
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        irq,
    // channel events from the stack
    input  wire        ch_evt_valid,
    output wire        ch_evt_ready,
    input  wire [7:0]  ch_evt_id,
    input  wire [7:0]  ch_handle,
    input  wire [15:0] ch_id,
    input  wire [15:0] ch_word,
    input  wire [15:0] ch_data_len,
    input  wire        pay_valid,
    output wire        pay_ready,
    input  wire [7:0]  pay_data,
    // pins and straps
    input  wire [7:0]  pin_in,
    input  wire        flash_256k,
    input  wire        prof_ctrl_pin,
    input  wire [4:0]  prof_status,
    // serial side
    output wire        tx_valid,
    input  wire        tx_ready,
    output wire [7:0]  tx_data,
    input  wire        host_rx_valid,
    input  wire [7:0]  host_rx_data,
    output wire        parser_valid,
    output wire [7:0]  parser_data,
    output wire        pipe_valid,
    output wire [7:0]  pipe_data
);

    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_HDR  = 2'd1;
    localparam [1:0] ST_PAY  = 2'd2;

    // ==========================================================
    // decode helpers
    function [2:0] reg_sel;
        input [7:0] addr;
        begin
            case (addr)
                `HEF_OFS_PIN_IRQ_EN: reg_sel = 3'd0;
                `HEF_OFS_PIN_FUNC:   reg_sel = 3'd1;
                `HEF_OFS_IRQ_STATUS: reg_sel = 3'd2;
                `HEF_OFS_IRQ_MASK:   reg_sel = 3'd3;
                `HEF_OFS_STATE:      reg_sel = 3'd4;
                default:             reg_sel = 3'd7;
            endcase
        end
    endfunction

    function is_ch_kind;
        input [7:0] id;
        begin
            is_ch_kind = (id >= `HEF_ID_DATA) && (id <= `HEF_ID_REJECT);
        end
    endfunction

    // ==========================================================
    // synchronisers and strap
    reg  [7:0]  pin_meta_reg, pin_sync_reg, pin_prev_reg;
    reg  [1:0]  ctrl_sync_reg;
    reg  [1:0]  flash_sync_reg;
    reg  [1:0]  strap_cnt_reg;
    reg         flash_ok_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg   <= 8'h00;
            pin_sync_reg   <= 8'h00;
            pin_prev_reg   <= 8'h00;
            ctrl_sync_reg  <= 2'b00;
            flash_sync_reg <= 2'b00;
            strap_cnt_reg  <= 2'h0;
            flash_ok_reg   <= 1'b0;
        end else begin
            pin_meta_reg   <= pin_in;
            pin_sync_reg   <= pin_meta_reg;
            pin_prev_reg   <= pin_sync_reg;
            ctrl_sync_reg  <= {ctrl_sync_reg[0], prof_ctrl_pin};
            flash_sync_reg <= {flash_sync_reg[0], flash_256k};
            if (strap_cnt_reg != 2'h3)
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == 2'h2)
                flash_ok_reg <= flash_sync_reg[1];
        end
    end

    // ==========================================================
    // timestamp
    reg  [15:0] div_reg;
    reg  [14:0] frac_reg;
    reg  [31:0] sec_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            div_reg  <= 16'h0000;
            frac_reg <= 15'h0000;
            sec_reg  <= 32'h0000_0000;
        end else if (div_reg == SUBSEC_CYC - 16'h0001) begin
            div_reg  <= 16'h0000;
            frac_reg <= frac_reg + 15'h0001;
            if (frac_reg == 15'h7FFF)
                sec_reg <= sec_reg + 32'h0000_0001;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    // ==========================================================
    // profile status and data mode
    wire [5:0]  cur_status;
    wire        data_mode;
    reg  [5:0]  last_status_reg;
    reg         stat_pend_reg;

    assign data_mode = (prof_status[`HEF_ST_UNACK] | prof_status[`HEF_ST_ACK])
                       & ctrl_sync_reg[1];
    assign cur_status = {data_mode, prof_status};

    // ==========================================================
    // register file and bus slave
    reg  [7:0]  pin_irq_en_reg, pin_func_reg;
    reg  [2:0]  irq_status_reg, irq_mask_reg, irq_set;
    reg         irq_reg;
    reg         awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    reg         aw_full_reg, w_full_reg;
    reg  [7:0]  awaddr_reg;
    reg  [7:0]  wbyte_reg;
    reg         wlane_reg;
    reg  [1:0]  bresp_reg, rresp_reg;
    reg  [31:0] rdata_reg;
    wire        wr_fire;
    wire [2:0]  wsel, rsel;
    wire [2:0]  irq_status_next;

    assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wsel    = reg_sel(awaddr_reg);
    assign rsel    = reg_sel(s_axi_araddr);
    assign irq_status_next = (irq_status_reg
        & ~((wr_fire && wsel == 3'd2 && wlane_reg) ? wbyte_reg[2:0] : 3'h0))
        | irq_set;

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg    <= 1'b0;
            wready_reg     <= 1'b0;
            bvalid_reg     <= 1'b0;
            arready_reg    <= 1'b0;
            rvalid_reg     <= 1'b0;
            aw_full_reg    <= 1'b0;
            w_full_reg     <= 1'b0;
            awaddr_reg     <= 8'h00;
            wbyte_reg      <= 8'h00;
            wlane_reg      <= 1'b0;
            bresp_reg      <= 2'b00;
            rresp_reg      <= 2'b00;
            rdata_reg      <= 32'h0000_0000;
            pin_irq_en_reg <= `HEF_RST_PIN_IRQ_EN;
            pin_func_reg   <= `HEF_RST_PIN_FUNC;
            irq_mask_reg   <= `HEF_RST_IRQ_MASK;
            irq_status_reg <= 3'h0;
            irq_reg        <= 1'b0;
        end else begin
            awready_reg <= s_axi_awvalid & ~aw_full_reg & ~awready_reg & ~bvalid_reg;
            wready_reg  <= s_axi_wvalid & ~w_full_reg & ~wready_reg & ~bvalid_reg;
            if (s_axi_awvalid && awready_reg) begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_full_reg <= 1'b1;
                wbyte_reg  <= s_axi_wdata[7:0];
                wlane_reg  <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (wsel == 3'd7) ? 2'b10 : 2'b00;
                if (wlane_reg) begin
                    if (wsel == 3'd0)
                        pin_irq_en_reg <= wbyte_reg;
                    if (wsel == 3'd1)
                        pin_func_reg <= wbyte_reg;
                    if (wsel == 3'd3)
                        irq_mask_reg <= wbyte_reg[2:0];
                end
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            arready_reg <= s_axi_arvalid & ~arready_reg & ~rvalid_reg;
            if (s_axi_arvalid && arready_reg) begin
                rvalid_reg <= 1'b1;
                rresp_reg  <= (rsel == 3'd7) ? 2'b10 : 2'b00;
                case (rsel)
                    3'd0:    rdata_reg <= {24'h000000, pin_irq_en_reg};
                    3'd1:    rdata_reg <= {24'h000000, pin_func_reg};
                    3'd2:    rdata_reg <= {29'h00000000, irq_status_reg};
                    3'd3:    rdata_reg <= {29'h00000000, irq_mask_reg};
                    3'd4:    rdata_reg <= {24'h000000, flash_ok_reg, 1'b0, cur_status};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
            irq_status_reg <= irq_status_next;
            irq_reg        <= |(irq_status_next & irq_mask_reg);
        end
    end

    // ==========================================================
    // serial routing
    reg         parser_valid_reg, pipe_valid_reg;
    reg  [7:0]  rx_byte_reg;
    reg         mode_prev_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            parser_valid_reg <= 1'b0;
            pipe_valid_reg   <= 1'b0;
            rx_byte_reg      <= 8'h00;
        end else begin
            parser_valid_reg <= host_rx_valid & ~data_mode;
            pipe_valid_reg   <= host_rx_valid & data_mode;
            if (host_rx_valid)
                rx_byte_reg <= host_rx_data;
        end
    end

    // ==========================================================
    // frame builder
    reg  [7:0]  fb [0:12];
    reg  [1:0]  state_reg;
    reg  [3:0]  hdr_len_reg, idx_reg;
    reg  [15:0] pay_left_reg;
    reg         drop_reg;
    reg         ch_ready_reg, pay_ready_reg;
    reg         tx_valid_reg;
    reg  [7:0]  tx_data_reg;
    reg  [7:0]  trig_acc_reg;
    wire [7:0]  trig_new;
    wire [7:0]  trig_out;
    wire        tx_free;
    wire        take_ch, take_pin, take_stat;

    assign trig_new  = (pin_sync_reg ^ pin_prev_reg) & pin_irq_en_reg
                       & ~pin_func_reg;
    assign trig_out  = trig_acc_reg & ~pin_func_reg;
    assign tx_free   = ~tx_valid_reg | tx_ready;
    assign take_ch   = (state_reg == ST_IDLE) & ch_evt_valid & ~ch_ready_reg;
    assign take_pin  = (state_reg == ST_IDLE) & ~take_ch & (|trig_out);
    assign take_stat = (state_reg == ST_IDLE) & ~take_ch & ~take_pin & stat_pend_reg;

    always @* begin
        irq_set = 3'h0;
        irq_set[`HEF_IRQ_MODE] = mode_prev_reg ^ data_mode;
        irq_set[`HEF_IRQ_DROP] = (take_ch & (~flash_ok_reg | data_mode
                                  | ~is_ch_kind(ch_evt_id)))
                                 | ((take_pin | take_stat) & data_mode);
        irq_set[`HEF_IRQ_SENT] = (state_reg == ST_HDR) & ~drop_reg & tx_free
                                 & (idx_reg == hdr_len_reg - 4'd1)
                                 & (pay_left_reg == 16'h0000);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg       <= ST_IDLE;
            hdr_len_reg     <= 4'd0;
            idx_reg         <= 4'd0;
            pay_left_reg    <= 16'h0000;
            drop_reg        <= 1'b0;
            ch_ready_reg    <= 1'b0;
            pay_ready_reg   <= 1'b0;
            tx_valid_reg    <= 1'b0;
            tx_data_reg     <= 8'h00;
            trig_acc_reg    <= 8'h00;
            stat_pend_reg   <= 1'b0;
            last_status_reg <= 6'h00;
            mode_prev_reg   <= 1'b0;
        end else begin
            ch_ready_reg  <= take_ch;
            pay_ready_reg <= 1'b0;
            mode_prev_reg <= data_mode;
            trig_acc_reg  <= (take_pin ? 8'h00 : trig_acc_reg) | trig_new;
            if (cur_status != last_status_reg) begin
                last_status_reg <= cur_status;
                stat_pend_reg   <= 1'b1;
            end else if (take_stat) begin
                stat_pend_reg <= 1'b0;
            end
            if (tx_valid_reg && tx_ready)
                tx_valid_reg <= 1'b0;
            fb[0] <= fb[0];
            case (state_reg)
                ST_IDLE: begin
                    idx_reg <= 4'd0;
                    fb[0]   <= `HEF_FRAME_TYPE;
                    if (take_ch) begin
                        state_reg <= ST_HDR;
                        drop_reg  <= ~flash_ok_reg | data_mode
                                     | ~is_ch_kind(ch_evt_id);
                        fb[2] <= `HEF_GRP_CHAN;
                        fb[3] <= ch_evt_id;
                        if (ch_evt_id == `HEF_ID_DATA) begin
                            fb[1]        <= `HEF_LEN_DATA;
                            fb[4]        <= ch_id[7:0];
                            fb[5]        <= ch_id[15:8];
                            fb[6]        <= ch_data_len[7:0];
                            fb[7]        <= ch_data_len[15:8];
                            hdr_len_reg  <= `HEF_HDR_DATA;
                            pay_left_reg <= ch_data_len;
                        end else begin
                            fb[1]        <= `HEF_LEN_CHAN;
                            fb[4]        <= ch_handle;
                            fb[5]        <= ch_id[7:0];
                            fb[6]        <= ch_id[15:8];
                            fb[7]        <= ch_word[7:0];
                            fb[8]        <= ch_word[15:8];
                            hdr_len_reg  <= `HEF_HDR_CHAN;
                            pay_left_reg <= 16'h0000;
                        end
                    end else if (take_pin) begin
                        state_reg    <= ST_HDR;
                        drop_reg     <= data_mode;
                        fb[1]        <= `HEF_LEN_PIN;
                        fb[2]        <= `HEF_GRP_PIN;
                        fb[3]        <= `HEF_ID_PIN;
                        fb[4]        <= PORT_NUM;
                        fb[5]        <= trig_out;
                        fb[6]        <= pin_sync_reg;
                        fb[7]        <= sec_reg[7:0];
                        fb[8]        <= sec_reg[15:8];
                        fb[9]        <= sec_reg[23:16];
                        fb[10]       <= sec_reg[31:24];
                        fb[11]       <= frac_reg[7:0];
                        fb[12]       <= {1'b0, frac_reg[14:8]};
                        hdr_len_reg  <= `HEF_HDR_PIN;
                        pay_left_reg <= 16'h0000;
                    end else if (take_stat) begin
                        state_reg    <= ST_HDR;
                        drop_reg     <= data_mode;
                        fb[1]        <= `HEF_LEN_PROF;
                        fb[2]        <= `HEF_GRP_PROF;
                        fb[3]        <= `HEF_ID_PROF;
                        fb[4]        <= {2'b00, cur_status};
                        hdr_len_reg  <= `HEF_HDR_PROF;
                        pay_left_reg <= 16'h0000;
                    end
                end
                ST_HDR: begin
                    if (drop_reg) begin
                        state_reg <= (pay_left_reg != 16'h0000) ? ST_PAY : ST_IDLE;
                    end else if (tx_free) begin
                        tx_valid_reg <= 1'b1;
                        tx_data_reg  <= fb[idx_reg];
                        idx_reg      <= idx_reg + 4'd1;
                        if (idx_reg == hdr_len_reg - 4'd1)
                            state_reg <= (pay_left_reg != 16'h0000) ? ST_PAY : ST_IDLE;
                    end
                end
                ST_PAY: begin
                    if (pay_valid && !pay_ready_reg && (drop_reg || tx_free)) begin
                        pay_ready_reg <= 1'b1;
                        pay_left_reg  <= pay_left_reg - 16'h0001;
                        if (!drop_reg) begin
                            tx_valid_reg <= 1'b1;
                            tx_data_reg  <= pay_data;
                        end
                        if (pay_left_reg == 16'h0001)
                            state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign irq           = irq_reg;
    assign ch_evt_ready  = ch_ready_reg;
    assign pay_ready     = pay_ready_reg;
    assign tx_valid      = tx_valid_reg;
    assign tx_data       = tx_data_reg;
    assign parser_valid  = parser_valid_reg;
    assign parser_data   = rx_byte_reg;
    assign pipe_valid    = pipe_valid_reg;
    assign pipe_data     = rx_byte_reg;

endmodule // hef_event_frames

// ===== verif/hef_host_model.sv
module hef_host_model (
    // clock and stall control
    input  logic       aclk,
    input  logic       slow,
    // serial bytes from the device
    input  logic       tx_valid,
    input  logic [7:0] tx_data,
    output logic       tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx_q[$];
    logic [1:0] ph = 2'h0;
    initial tx_ready = 1'b1;
    // ====
    // byte capture, stalls three cycles of four when slow
    always @(posedge aclk) begin
        if (tx_valid && tx_ready) rx_q.push_back(tx_data);
        ph <= ph + 2'h1;
        tx_ready <= !slow || ph == 2'h3;
    end
endmodule // hef_host_model

// ===== verif/hef_event_frames_sva.sv
module hef_event_frames_sva (
    // clock and reset
    input logic        aclk,
    input logic        aresetn,
    // register bus
    input logic        s_axi_awready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // events
    input logic        ch_evt_ready,
    input logic [7:0]  ch_evt_id,
    input logic        flash_256k,
    input logic [4:0]  prof_status,
    input logic        pay_ready,
    // serial
    input logic        tx_valid,
    input logic        tx_ready,
    input logic [7:0]  tx_data,
    input logic        host_rx_valid,
    input logic [7:0]  host_rx_data,
    input logic        parser_valid,
    input logic [7:0]  parser_data,
    input logic        pipe_valid,
    input logic [7:0]  pipe_data
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ====
    // checks
    a_frame_start: assert property (
        ch_evt_ready && flash_256k && prof_status[1:0] == 2'h0 && ch_evt_id inside {[3:7]}
        |-> ##[1:2] tx_valid && tx_data == 8'h80) else $error("frame without type byte");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("tx byte dropped while stalled");
    a_rx_route: assert property (host_rx_valid |=> (parser_valid ^ pipe_valid) &&
        (pipe_valid ? pipe_data : parser_data) == $past(host_rx_data)) else $error("rx misrouted");
    a_pay_gap: assert property (pay_ready |=> !pay_ready) else $error("payload too fast");
    a_evt_pulse: assert property (ch_evt_ready |=> !ch_evt_ready) else $error("event ready held");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule // hef_event_frames_sva

bind hef_event_frames hef_event_frames_sva i_hef_event_frames_sva (.*);

// ===== verif/hef_event_frames_tb_top.sv
module hef_event_frames_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, slow, irq, flash_256k, prof_ctrl_pin;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        ch_evt_valid, ch_evt_ready, pay_valid, pay_ready, tx_valid, tx_ready;
    logic        host_rx_valid, parser_valid, pipe_valid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [4:0]  prof_status;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, ch_evt_id, ch_handle, pay_data, pin_in;
    logic [7:0]  tx_data, host_rx_data, parser_data, pipe_data;
    logic [15:0] ch_id, ch_word, ch_data_len;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    int          err_total, n_checks, k;
    hef_event_frames #(.PORT_NUM(8'h05), .SUBSEC_CYC(16'h0004)) i_hef_event_frames (.*);
    hef_host_model i_hef_host_model (.*);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // ====
    // tasks
    task automatic wrap_up;
        if (err_total == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic step(inout int c);
        @(posedge aclk);
        c++;
        if (c > 400) begin
            err_total++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        int c = 0;
        logic aw = 1'b0;
        logic w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            step(c);
            if (s_axi_awready === 1'b1) aw = 1'b1;
            if (s_axi_wready === 1'b1) w = 1'b1;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        do step(c); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b1;
        step(c);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int c = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do step(c); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do step(c); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        step(c);
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er);
        if (er == 2'h0) chk(s_axi_rdata, e);
    endtask
    task automatic ev(input logic [7:0] id, input logic [15:0] n);
        int c = 0;
        ch_evt_id <= id;
        ch_word <= {id, 8'hC3};
        ch_data_len <= n;
        ch_evt_valid <= 1'b1;
        do step(c); while (ch_evt_ready !== 1'b1);
        ch_evt_valid <= 1'b0;
        for (int i = 0; i < n; i++) begin
            pay_data <= 8'hA0 + 8'(i);
            pay_valid <= 1'b1;
            do step(c); while (pay_ready !== 1'b1);
            pay_valid <= 1'b0;
            step(c);
        end
    endtask
    task automatic fr(input int n, input logic [79:0] v);
        int c = 0;
        while (i_hef_host_model.rx_q.size() < n) step(c);
        for (int i = 0; i < n; i++) chk(i_hef_host_model.rx_q.pop_front(), v[8*(n-1-i) +: 8]);
    endtask
    task automatic rx(input logic [7:0] b, input logic [9:0] e);
        {host_rx_valid, host_rx_data} <= {1'b1, b};
        @(posedge aclk);
        host_rx_valid <= 1'b0;
        @(posedge aclk);
        chk({parser_valid, pipe_valid, parser_data | pipe_data}, e);
    endtask
    task automatic quiet;
        repeat (40) @(posedge aclk);
        chk(i_hef_host_model.rx_q.size(), 0);
    endtask
    task automatic rst;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask
    // ====
    // sequence
    initial begin
        {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, ch_evt_valid, pay_valid, host_rx_valid, pin_in, prof_status} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ch_evt_id, ch_word, ch_data_len} = '0;
        {pay_data, host_rx_data, err_total, n_checks, k} = '0;
        {s_axi_wstrb, ch_handle, ch_id} = {4'hF, 8'h3C, 16'h1234};
        {flash_256k, prof_ctrl_pin} = 2'h2;
        rst();
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h0C, 32'h0, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        wr(8'h24, 32'h1, 2'h2);
        for (int i = 4; i < 8; i++) begin
            slow <= (i == 5);
            ev(8'(i), 16'h0);
            fr(9, {8'h80, 8'h05, 8'h08, 8'(i), 8'h3C, 8'h34, 8'h12, 8'hC3, 8'(i)});
            if (i == 5) rx(8'h5A, 10'h25A);
        end
        ev(8'h03, 16'h0002);
        fr(10, {8'h80, 8'h04, 8'h08, 8'h03, 8'h34, 8'h12, 8'h02, 8'h00, 8'hA0, 8'hA1});
        wr(8'h0C, 32'h2, 2'h0);
        wr(8'h08, 32'h7, 2'h0);
        ev(8'h09, 16'h0);
        quiet();
        chk(irq, 1'b1);
        wr(8'h08, 32'h2, 2'h0);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(8'h00, 32'h1, 2'h0);
        rd(8'h00, 32'h1, 2'h0);
        pin_in <= 8'h02;
        quiet();
        pin_in <= 8'h03;
        fr(7, {8'h80, 8'h09, 8'h09, 8'h01, 8'h05, 8'h01, 8'h03});
        while (i_hef_host_model.rx_q.size() < 6) step(k);
        chk(i_hef_host_model.rx_q[5][7], 1'b0);
        i_hef_host_model.rx_q.delete();
        wr(8'h04, 32'h1, 2'h0);
        pin_in <= 8'h02;
        quiet();
        {prof_ctrl_pin, prof_status} <= {1'b0, 5'h02};
        fr(5, {8'h80, 8'h01, 8'h0A, 8'h01, 8'h02});
        prof_ctrl_pin <= 1'b1;
        quiet();
        rd(8'h10, 32'hA2, 2'h0);
        rx(8'h3E, 10'h13E);
        ev(8'h04, 16'h0);
        quiet();
        prof_status <= 5'h00;
        fr(5, {8'h80, 8'h01, 8'h0A, 8'h01, 8'h00});
        flash_256k <= 1'b0;
        rst();
        ev(8'h05, 16'h0);
        quiet();
        wrap_up();
    end
endmodule // hef_event_frames_tb_top
